//--- pkg/subclk_cfg_pkg.sv
// Purpose: Shared constants and types for the subclock and oscillator configuration block.
// Assumes: One 8-bit control register reached over a plain strobe port.
// Notes:   Field positions and reset values are named here once.
package subclk_cfg_pkg;

  // Register map and widths.
  localparam int         ADDR_W           = 4;
  localparam logic [3:0] LPC_ADDR         = 4'h0;
  localparam logic [7:0] LPC_RESET        = 8'h00;

  // Field positions inside the control register.
  localparam int         POS_UPPER_LO     = 6;
  localparam int         POS_SAMPLE_SEL   = 5;
  localparam int         POS_SUB_STOP     = 4;
  localparam int         POS_FB_BYPASS    = 3;
  localparam int         POS_RESERVED     = 2;
  localparam int         POS_MULT_LO      = 0;

  // Noise sampling divide ratios and their terminal counts.
  localparam int         SAMPLE_DIV_SLOW  = 8;
  localparam int         SAMPLE_DIV_FAST  = 4;
  localparam logic [2:0] TC_SLOW          = 3'(SAMPLE_DIV_SLOW - 1);
  localparam logic [2:0] TC_FAST          = 3'(SAMPLE_DIV_FAST - 1);

  // Applied multiplier reset value.
  localparam logic [1:0] MULT_RESET       = 2'h0;

  // Control register layout, bit 7 down to bit 0.
  typedef struct packed {
    logic [1:0] upper_mode;
    logic       sample_rate_select;
    logic       subclock_stop;
    logic       feedback_bypass;
    logic       reserved;
    logic       mult_factor_hi;
    logic       mult_factor_lo;
  } low_power_control_t;

  // Settings that reach the oscillator only on a low-power entry.
  typedef struct packed {
    logic       feedback_bypass;
    logic [1:0] mult_factor;
  } applied_cfg_t;

  // Operating state reported by the power mode controller, Gray coded along the wake path.
  typedef enum logic [2:0] {
    PS_HIGH_SPEED   = 3'h0,
    PS_MEDIUM_SPEED = 3'h1,
    PS_SLEEP        = 3'h3,
    PS_SW_STANDBY   = 3'h2,
    PS_WATCH        = 3'h6,
    PS_SUBACTIVE    = 3'h7,
    PS_SUBSLEEP     = 3'h5
  } power_state_t;

  // Decoded multiplier setting.
  typedef enum logic [1:0] {
    MULT_X1     = 2'h0,
    MULT_X2     = 2'h1,
    MULT_X4     = 2'h2,
    MULT_BYPASS = 2'h3
  } mult_mode_t;

endpackage

//--- verilog/pin_sync3.sv
// Purpose: Brings an asynchronous pin level into the ref_clk domain.
// Assumes: The pin is slow compared with ref_clk.
// Notes:   Output changes only once the second and third stages agree.
`timescale 1ns/100ps
`default_nettype none
module pin_sync3 (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic nrst,
  // Pin and result
  input  wire logic pin_in,
  output logic      level_out
);

  logic       meta_reg;
  logic [1:0] stage_reg;
  logic       level_reg;

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      meta_reg  <= 1'b0;
      stage_reg <= 2'h0;
    end else begin
      meta_reg  <= pin_in;
      stage_reg <= {stage_reg[0], meta_reg};
    end
  end

  // Stage one is never looked at; only stages two and three vote.
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      level_reg <= 1'b0;
    end else if (stage_reg[0] == stage_reg[1]) begin
      level_reg <= stage_reg[1];
    end
  end

  assign level_out = level_reg;

endmodule
`default_nettype wire

//--- verilog/subclock_and_oscillator_config.sv
// Purpose: Holds the low-power control register clock fields and drives oscillator controls.
// Assumes: power_state comes from the mode controller on ref_clk; subclk_pin is asynchronous.
// Notes:   Bypass and multiplier settings reach the oscillator only on a low-power entry.
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// (R1) Sample subclock at system clock /8 when select is 0, /4 when 1.
// (R2) Software keeps sampling select at 0 when system clock is 5 MHz or faster.
// (R3) Subclock oscillator runs while stop bit is 0, halts while it is 1.
// (R4) Software sets subclock stop when the subclock is unused.
// (R5) Bypass 0 uses feedback resistor and duty adjust; 1 disables both.
// (R6) A bypass change applies only on entering standby, watch or subactive.
// (R7) Software leaves bypass alone with a crystal; enters low power after setting it.
// (R8) Bit 2 is readable and writable; software writes only zero.
// (R9) Multiplier: 00 x1, 01 x2, 10 x4, 11 multiplier bypassed.
// (R10) A new multiplier applies only after entering standby, watch or subactive.
// (R11) Reset clears both multiplier bits.
// (R12) Software sets both multiplier bits after every reset.
// (R13) Inverted external clock is held high in standby and subclock states.
// (R14) Without duty adjust the external clock passes through unreshaped.
// (R15) Whole register clears on reset and hardware standby, kept in software standby.
// (R16) Noise sampling stops in subactive, subsleep and watch.
// (R17) Subclock passes a synchroniser before sampling logic uses it.
module subclock_and_oscillator_config (
  // Clock and reset
  input  wire logic                                ref_clk,
  input  wire logic                                nrst,
  // Register port
  input  wire logic [subclk_cfg_pkg::ADDR_W-1:0]   reg_addr,
  input  wire logic [7:0]                          reg_wdata,
  input  wire logic                                reg_wr,
  input  wire logic                                reg_rd,
  output logic      [7:0]                          reg_rdata,
  // Power mode controller
  input  wire subclk_cfg_pkg::power_state_t        power_state,
  input  wire logic                                hw_standby,
  // Subclock pin and shaped result
  input  wire logic                                subclk_pin,
  output logic                                     subclk_shaped,
  // Oscillator controls
  output logic                                     subclk_osc_run,
  output logic                                     feedback_res_on,
  output logic                                     duty_adjust_on,
  output logic                                     ext_clk_passthrough,
  output subclk_cfg_pkg::mult_mode_t               mult_mode,
  output logic [1:0]                               upper_mode
);

  subclk_cfg_pkg::low_power_control_t lpc_reg;
  subclk_cfg_pkg::applied_cfg_t       applied_reg;
  subclk_cfg_pkg::power_state_t       prev_state_reg;
  logic [7:0]                         rdata_reg;
  logic [2:0]                         div_cnt_reg;
  logic                               sample_reg;
  logic                               shaped_reg;
  logic                               sub_sync;
  logic                               lp_entry;
  logic                               suspend;
  logic                               tick;
  logic [2:0]                         tc;
  logic                               lpc_hit;

  function automatic logic is_apply_state(input subclk_cfg_pkg::power_state_t s);
    is_apply_state = (s == subclk_cfg_pkg::PS_SW_STANDBY) || (s == subclk_cfg_pkg::PS_WATCH) ||
                     (s == subclk_cfg_pkg::PS_SUBACTIVE);
  endfunction

  function automatic subclk_cfg_pkg::mult_mode_t mult_decode(input logic [1:0] f);
    case (f)
      2'h0:    mult_decode = subclk_cfg_pkg::MULT_X1;
      2'h1:    mult_decode = subclk_cfg_pkg::MULT_X2;
      2'h2:    mult_decode = subclk_cfg_pkg::MULT_X4;
      default: mult_decode = subclk_cfg_pkg::MULT_BYPASS;
    endcase
  endfunction

  assign lpc_hit = (reg_addr == subclk_cfg_pkg::LPC_ADDR);

  // Control register; software standby does not touch it.
  always_ff @(posedge ref_clk) begin
    if (!nrst || hw_standby) begin
      lpc_reg <= subclk_cfg_pkg::LPC_RESET; // R15 R11
    end else if (reg_wr && lpc_hit) begin
      lpc_reg <= reg_wdata; // R8
    end
  end

  // Read data stand for exactly one cycle; unmapped addresses read zero.
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      rdata_reg <= 8'h00;
    end else if (reg_rd && lpc_hit) begin
      rdata_reg <= lpc_reg;
    end else begin
      rdata_reg <= 8'h00;
    end
  end

  assign reg_rdata = rdata_reg;

  // Entry edge into a state that latches the oscillator settings.
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      prev_state_reg <= subclk_cfg_pkg::PS_HIGH_SPEED;
    end else begin
      prev_state_reg <= power_state;
    end
  end

  assign lp_entry = is_apply_state(power_state) && !is_apply_state(prev_state_reg);

  // Writes are staged in the register and only copied here on entry.
  always_ff @(posedge ref_clk) begin
    if (!nrst || hw_standby) begin
      applied_reg.feedback_bypass <= 1'b0;
      applied_reg.mult_factor     <= subclk_cfg_pkg::MULT_RESET;
    end else if (lp_entry) begin
      applied_reg.feedback_bypass <= lpc_reg.feedback_bypass; // R6
      applied_reg.mult_factor     <= {lpc_reg.mult_factor_hi, lpc_reg.mult_factor_lo}; // R10
    end
  end

  assign feedback_res_on     = !applied_reg.feedback_bypass; // R5
  assign duty_adjust_on      = !applied_reg.feedback_bypass; // R5
  // With duty adjust off the oscillator buffer hands the input edge straight on.
  assign ext_clk_passthrough = applied_reg.feedback_bypass; // R14
  assign mult_mode           = mult_decode(applied_reg.mult_factor); // R9
  assign subclk_osc_run      = !lpc_reg.subclock_stop; // R3
  assign upper_mode          = lpc_reg.upper_mode;

  pin_sync3 u_sub_sync (
    .ref_clk   (ref_clk),
    .nrst      (nrst),
    .pin_in    (subclk_pin),
    .level_out (sub_sync)
  ); // R17

  assign suspend = (power_state == subclk_cfg_pkg::PS_SUBACTIVE) ||
                   (power_state == subclk_cfg_pkg::PS_SUBSLEEP) ||
                   (power_state == subclk_cfg_pkg::PS_WATCH);
  assign tc      = lpc_reg.sample_rate_select ? subclk_cfg_pkg::TC_FAST : subclk_cfg_pkg::TC_SLOW;
  assign tick    = !suspend && (div_cnt_reg >= tc);

  // Sampling divider; holds its count while suspended.
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      div_cnt_reg <= 3'h0;
    end else if (suspend) begin
      div_cnt_reg <= div_cnt_reg; // R16
    end else if (tick) begin
      div_cnt_reg <= 3'h0; // R1
    end else begin
      div_cnt_reg <= div_cnt_reg + 3'h1;
    end
  end

  // A level is accepted only when two successive samples match, which rejects short glitches.
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      sample_reg <= 1'b0;
      shaped_reg <= 1'b0;
    end else if (tick) begin
      sample_reg <= sub_sync; // R1
      if (sample_reg == sub_sync) begin
        shaped_reg <= sub_sync;
      end
    end
  end

  assign subclk_shaped = shaped_reg;

  AST_DIV8_SPACING: assert property (@(posedge ref_clk) disable iff (!nrst) // R1
    (tick && !lpc_reg.sample_rate_select) ##1 (!suspend && !lpc_reg.sample_rate_select)[*7] |->
      (!tick && !$past(tick) && !$past(tick, 2) && !$past(tick, 3) && !$past(tick, 4) && !$past(tick, 5) &&
       !$past(tick, 6)) ##1 (suspend || tick))
    else $error("slow sampling tick not every 8 cycles");

  AST_DIV4_SPACING: assert property (@(posedge ref_clk) disable iff (!nrst) // R1
    (tick && lpc_reg.sample_rate_select) ##1 (!suspend && lpc_reg.sample_rate_select)[*3] |->
      (!tick && !$past(tick) && !$past(tick, 2)) ##1 (suspend || tick || !lpc_reg.sample_rate_select))
    else $error("fast sampling tick not every 4 cycles");

  AST_STOP_WRITE: assert property (@(posedge ref_clk) disable iff (!nrst || hw_standby) // R3
    (reg_wr && lpc_hit) |=> (subclk_osc_run == !$past(reg_wdata[subclk_cfg_pkg::POS_SUB_STOP])))
    else $error("subclock run does not follow stop bit write");

  AST_BYPASS_HELD: assert property (@(posedge ref_clk) disable iff (!nrst || hw_standby) // R6
    !lp_entry |=> $stable(duty_adjust_on) && $stable(feedback_res_on))
    else $error("bypass changed without low-power entry");

  AST_BYPASS_APPLY: assert property (@(posedge ref_clk) disable iff (!nrst || hw_standby) // R5
    lp_entry |=> (ext_clk_passthrough == $past(lpc_reg.feedback_bypass)) && (duty_adjust_on != ext_clk_passthrough))
    else $error("bypass not applied on entry");

  AST_MULT_APPLY: assert property (@(posedge ref_clk) disable iff (!nrst || hw_standby) // R10
    lp_entry |=> mult_mode == mult_decode($past({lpc_reg.mult_factor_hi, lpc_reg.mult_factor_lo})))
    else $error("multiplier not applied on entry");

  AST_MULT_HELD: assert property (@(posedge ref_clk) disable iff (!nrst || hw_standby) // R10
    (reg_wr && lpc_hit && !lp_entry) |=> $stable(mult_mode))
    else $error("multiplier moved on a plain write");

  AST_HWSTBY_CLEAR: assert property (@(posedge ref_clk) disable iff (!nrst) // R15
    hw_standby |=> (lpc_reg == subclk_cfg_pkg::LPC_RESET) && (mult_mode == subclk_cfg_pkg::MULT_X1))
    else $error("hardware standby did not clear register");

  AST_SUSPEND: assert property (@(posedge ref_clk) disable iff (!nrst) // R16
    suspend |-> !tick ##1 $stable(shaped_reg))
    else $error("sampling active in subclock state");

  AST_READBACK: assert property (@(posedge ref_clk) disable iff (!nrst) // R8
    (reg_rd && lpc_hit) |=> reg_rdata == $past(lpc_reg))
    else $error("read data mismatch");

  AST_RESET_MULT: assert property (@(posedge ref_clk) // R11
    !nrst |=> (mult_mode == subclk_cfg_pkg::MULT_X1) && !lpc_reg.mult_factor_hi && !lpc_reg.mult_factor_lo)
    else $error("reset left a multiplier bit set");

  AST_SW_STBY_RETAIN: assert property (@(posedge ref_clk) disable iff (!nrst) // R15
    (power_state == subclk_cfg_pkg::PS_SW_STANDBY) && !hw_standby && !(reg_wr && lpc_hit) |=> $stable(lpc_reg))
    else $error("register lost its contents in software standby");

  AST_SYNC_LAG: assert property (@(posedge ref_clk) disable iff (!nrst) // R17
    $changed(sub_sync) |-> (sub_sync == $past(subclk_pin, 3)) && (sub_sync == $past(subclk_pin, 4)))
    else $error("synchronised subclock moved ahead of its pin");

endmodule
`default_nettype wire

//--- dv/subclk_source.sv
// Purpose: Behavioural model of the clock source that feeds the subclock pin.
// Assumes: The bench asks for a pin level; the mode controller state is shared.
// Notes:   The source parks high in every standby and subclock state.
`timescale 1ns/100ps
`default_nettype none
module subclk_source (
  // Mode seen by the source
  input  wire subclk_cfg_pkg::power_state_t power_state,
  // Requested level and pin
  input  wire logic                         level_req,
  output logic                              subclk_pin
);
  logic parked;

  // Holding the pin high keeps an inverted input stage from burning current.
  assign parked = (power_state != subclk_cfg_pkg::PS_HIGH_SPEED)
               && (power_state != subclk_cfg_pkg::PS_MEDIUM_SPEED)
               && (power_state != subclk_cfg_pkg::PS_SLEEP);

  always_comb begin
    subclk_pin = parked ? 1'b1 : level_req;
  end
endmodule
`default_nettype wire

//--- dv/subclock_and_oscillator_config_test.sv
// Purpose: Self-checking bench for the subclock and oscillator configuration block.
// Assumes: One 100 MHz clock; the control register sits at address 4'h0.
// Notes:   Sampling latency is judged against a window, since the divider phase is free.
`timescale 1ns/100ps
`default_nettype none
module subclock_and_oscillator_config_test;
  logic                         ref_clk = 1'b0;
  logic                         nrst = 1'b0;
  logic [3:0]                   reg_addr = 4'h0;
  logic [7:0]                   reg_wdata = 8'h00;
  logic                         reg_wr = 1'b0;
  logic                         reg_rd = 1'b0;
  logic                         hw_standby = 1'b0;
  logic                         level_req = 1'b0;
  subclk_cfg_pkg::power_state_t power_state = subclk_cfg_pkg::PS_HIGH_SPEED;
  logic [7:0]                   reg_rdata;
  logic                         subclk_pin, subclk_shaped, subclk_osc_run;
  logic                         feedback_res_on, duty_adjust_on, ext_clk_passthrough;
  subclk_cfg_pkg::mult_mode_t   mult_mode;
  logic [1:0]                   upper_mode;
  logic [7:0]                   app;
  int                           err_total = 0;
  int                           checked = 0;
  int                           cycles = 0;
  subclk_cfg_pkg::power_state_t apply_s [3] = '{subclk_cfg_pkg::PS_SW_STANDBY, subclk_cfg_pkg::PS_WATCH,
                                              subclk_cfg_pkg::PS_SUBACTIVE};

  subclock_and_oscillator_config uut (.ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .power_state(power_state), .hw_standby(hw_standby), .subclk_pin(subclk_pin),
    .subclk_shaped(subclk_shaped), .subclk_osc_run(subclk_osc_run), .feedback_res_on(feedback_res_on),
    .duty_adjust_on(duty_adjust_on), .ext_clk_passthrough(ext_clk_passthrough), .mult_mode(mult_mode),
    .upper_mode(upper_mode));
  subclk_source src (.power_state(power_state), .level_req(level_req), .subclk_pin(subclk_pin));

  always #5 ref_clk = ~ref_clk;

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // A hang costs one mismatch and still ends in the report.
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_total++;
      print_verdict();
    end
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 check(reg_rdata, exp);
    @(posedge ref_clk);
  endtask

  task automatic outs(input logic [7:0] exp);
    #1 check({subclk_osc_run, feedback_res_on, duty_adjust_on, ext_clk_passthrough, mult_mode, upper_mode}, exp);
    @(posedge ref_clk);
  endtask

  task automatic enter(input subclk_cfg_pkg::power_state_t s);
    power_state <= s;
    repeat (2) @(posedge ref_clk);
  endtask

  // Latency from a pin change to the shaped output must fall inside lo..hi cycles.
  task automatic sample(input logic lvl, input int lo, input int hi);
    int lat;
    level_req <= lvl;
    lat = 0;
    do begin
      @(posedge ref_clk);
      #1 lat = lat + 1;
    end while (subclk_shaped !== lvl && lat < 40);
    check(8'(lat >= lo && lat <= hi), 8'h01);
    @(posedge ref_clk);
  endtask

  initial begin
    repeat (3) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    outs(8'he0);
    rd(4'h0, 8'h00);
    wr(4'h0, 8'hd3);
    outs(8'h63);
    rd(4'h0, 8'hd3);
    wr(4'h0, 8'h04);
    rd(4'h0, 8'h04);
    wr(4'h5, 8'hff);
    rd(4'h5, 8'h00);
    rd(4'h0, 8'h04);
    app = 8'he0;
    for (int i = 0; i < 4; i++) begin
      wr(4'h0, {4'h0, i[0], 1'b0, 2'(3 - i)});
      outs(app);
      enter(apply_s[i % 3]);
      app = {1'b1, ~i[0], ~i[0], i[0], 2'(3 - i), 2'b00};
      outs(app);
      enter(subclk_cfg_pkg::PS_HIGH_SPEED);
    end
    enter(subclk_cfg_pkg::PS_SW_STANDBY);
    wr(4'h0, 8'h03);
    // Standby to watch is not a fresh entry, so the staged write must stay staged.
    enter(subclk_cfg_pkg::PS_WATCH);
    outs(app);
    rd(4'h0, 8'h03);
    hw_standby <= 1'b1;
    power_state <= subclk_cfg_pkg::PS_HIGH_SPEED;
    @(posedge ref_clk);
    hw_standby <= 1'b0;
    @(posedge ref_clk);
    outs(8'he0);
    rd(4'h0, 8'h00);
    // The parked pin left stale samples behind; two slow ticks on a low pin flush them.
    repeat (20) @(posedge ref_clk);
    check({7'h00, subclk_shaped}, 8'h00);
    sample(1'b1, 13, 20);
    // The fast rate exceeds the software speed limit at this clock; it is set only to prove the divide select.
    wr(4'h0, 8'h20);
    repeat (16) @(posedge ref_clk);
    sample(1'b0, 9, 12);
    enter(subclk_cfg_pkg::PS_WATCH);
    repeat (40) @(posedge ref_clk);
    check({7'h00, subclk_shaped}, 8'h00);
    print_verdict();
  end
endmodule
`default_nettype wire
